// *** src/psf_pkg.sv ***
// Constants, field layout and carrier types of the PIN state and file
// activation command handler.
// Assumes a single 50 MHz clock domain shared by all users of the package.
package psf_pkg;

  // ==========================================================
  // Retry counters and parameter codes
  localparam logic [1:0] PIN_INIT_TRIES = 2'h3; // Initial PIN attempts
  localparam logic [3:0] UNBLK_INIT_TRIES = 4'ha; // Initial unblock tries
  localparam logic [7:0] LC_EMPTY = 8'h00;
  localparam logic [7:0] LC_ENABLE = 8'h08; // Enable carries 8 bytes
  localparam logic [7:0] LC_UNBLOCK = 8'h10; // Unblock value + new PIN
  localparam logic [7:0] P1_ZERO = 8'h00;
  localparam logic [7:0] P1_PATH_ROOT = 8'h08; // Path from root_file
  localparam logic [7:0] P1_PATH_DF = 8'h09; // Path from directory_file
  localparam logic [7:0] USE_QUAL_NONE = 8'h00; // Do-not-use qualifier

  // ==========================================================
  // Status words
  localparam logic [15:0] SW_OK = 16'h9000;
  localparam logic [11:0] SW_RETRY_BASE = 12'h63c; // Low nibble = tries
  localparam logic [15:0] SW_BLOCKED = 16'h6983;
  localparam logic [15:0] SW_COND = 16'h6985;
  localparam logic [15:0] SW_SECURITY = 16'h6982;
  localparam logic [15:0] SW_BAD_LEN = 16'h6700;
  localparam logic [15:0] SW_BAD_P1P2 = 16'h6a86;
  localparam logic [15:0] SW_NO_FILE = 16'h6a82;
  localparam logic [15:0] SW_NO_REF = 16'h6a88;
  localparam logic [15:0] SW_INVALID = 16'h6283;

  // ==========================================================
  // Register offsets (byte addresses) and field positions
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SEL = 8'h04;
  localparam logic [7:0] REG_PIN_LO = 8'h08;
  localparam logic [7:0] REG_PIN_HI = 8'h0c;
  localparam logic [7:0] REG_UNBLK_LO = 8'h10;
  localparam logic [7:0] REG_UNBLK_HI = 8'h14;
  localparam logic [7:0] REG_PIN_STAT = 8'h18;
  localparam logic [7:0] REG_FILE_CFG = 8'h1c;
  localparam logic [7:0] REG_CURSOR = 8'h20;
  localparam int CTRL_FORMAT_BIT = 0;
  localparam int SEL_FILE_LSB = 8;
  localparam int STAT_UCNT_LSB = 4;
  localparam int STAT_EN_BIT = 8;
  localparam int STAT_BLK_BIT = 9;
  localparam int STAT_UBLK_BIT = 10;
  localparam int STAT_VER_BIT = 11;
  localparam int STAT_QUAL_LSB = 16;
  localparam int FCFG_DEACT_OK_BIT = 16;
  localparam int FCFG_ACT_OK_BIT = 17;
  localparam int FCFG_DEACT_BIT = 18;
  localparam int CUR_DF_LSB = 16;

  // ==========================================================
  // Carrier types
  typedef enum logic [2:0] {
    PSF_ENABLE = 3'b000,
    PSF_UNBLOCK = 3'b001,
    PSF_DEACT = 3'b010,
    PSF_ACT = 3'b011,
    PSF_FILE_OP = 3'b100
  } psf_kind_t;

  typedef struct packed {
    psf_kind_t kind;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] lc;
    logic [0:15][7:0] data; // data[0] is the first command byte
  } psf_cmd_t;

endpackage

// *** src/psf_handler.sv ***
// Card-side handler for PIN enable, PIN unblock and file (de)activation.
// Assumes framed commands arrive from logic on clk, one per cmd_valid pulse,
// and that software reaches the registers over a plain strobe port.
//
// How it works
// - Enable clears replacement key qualifier to 00
// - Enable refused when PIN enabled or blocked
// - Correct enable: counter 3, comparison on
// - Wrong enable: decrement counter; enable unchanged, block loads BLOCK_SETS_ENABLE
// - Three failures block; only unblock or format clears block
// - Blocked disabled grants, blocked enabled denies
// - Enable: P1 zero, eight data bytes
// - Unblock allowed unless unblock PIN blocked
// - Correct unblock: new PIN, counters reset, enable
// - Wrong unblock decrements, answers 63C9..63C1
// - Tenth failure blocks, 63C0; then 6983
// - Wrong unblock leaves PIN state untouched
// - Empty unblock reports remaining tries 63CX
// - Empty query on blocked unblock PIN answers
// - Unblock: empty or sixteen bytes, P1 zero
// - Deactivate marks file when condition met
// - Activate clears mark when condition met
// - Success makes target the current file
// - Failure keeps current files unchanged
// - Deactivated file refuses other operations
// - File commands: P2 zero, P1 selects target
// - Empty data, zero parameters: current file
// - P2 carries reference number 01 to NUM_PIN
module psf_handler #(
  parameter int NUM_PIN = 4,
  parameter int NUM_FILE = 8,
  parameter bit BLOCK_SETS_ENABLE = 1'b0,
  parameter logic [15:0] ROOT_FILE_ID = 16'h0001
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire psf_pkg::psf_cmd_t cmd,
  output logic rsp_valid,
  output logic [15:0] rsp_sw,
  output logic [7:0] cur_ef,
  output logic [NUM_PIN-1:0] ac_granted,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  localparam int PW = (NUM_PIN > 1) ? $clog2(NUM_PIN) : 1;
  localparam int FW = (NUM_FILE > 1) ? $clog2(NUM_FILE) : 1;
  // ==========================================================
  // Persistent state (kept across rst, cleared only by format)
  logic [63:0] pin_val_reg [NUM_PIN]; // Reference PIN values
  logic [63:0] unblk_val_reg [NUM_PIN]; // Reference unblock values
  logic [1:0] pin_cnt_reg [NUM_PIN]; // Remaining PIN attempts
  logic [3:0] unblk_cnt_reg [NUM_PIN]; // Remaining unblock attempts
  logic [NUM_PIN-1:0] pin_en_reg; // Comparison required
  logic [NUM_PIN-1:0] pin_blk_reg; // PIN blocked
  logic [NUM_PIN-1:0] unblk_blk_reg; // Unblock PIN blocked
  logic [7:0] qual_reg [NUM_PIN]; // Replacement key usage qualifier
  logic [15:0] file_id_reg [NUM_FILE]; // Identifier of each file
  logic [NUM_FILE-1:0] deact_ok_reg; // Deactivate condition met
  logic [NUM_FILE-1:0] act_ok_reg; // Activate condition met
  logic [NUM_FILE-1:0] file_deact_reg; // Life-cycle deactivated flag
  // Session state
  logic [NUM_PIN-1:0] verified_reg; // Access level reached this session
  logic [FW-1:0] cur_ef_reg; // Current elementary_file
  logic [15:0] cur_df_reg; // Current directory_file
  logic [PW-1:0] sel_pin_reg; // Register window onto one PIN
  logic [FW-1:0] sel_file_reg; // Register window onto one file
  logic rsp_valid_reg;
  logic [15:0] rsp_sw_reg;
  logic [31:0] rdata_reg;
  logic [NUM_PIN-1:0] ac_reg;
  // ==========================================================
  // Command decode
  logic [15:0] sw_next; // Status word to answer
  logic pin_ok; // Reference number valid
  logic [PW-1:0] pidx; // Addressed PIN
  logic pin_match; // First eight bytes equal stored value
  logic en_good; // Enable with correct PIN
  logic en_bad; // Enable with wrong PIN
  logic ub_good; // Unblock with correct value
  logic ub_bad; // Unblock with wrong value
  logic file_do; // (De)activation takes effect
  logic [FW-1:0] fidx; // Target file
  logic [63:0] first8; // Bytes 1..8 of data
  logic [63:0] second8; // Bytes 9..16 of data
  logic [15:0] tgt_id; // Identifier named by the data field
  logic found; // Target identifier exists
  logic [1:0] pin_dec; // Counter after a failure
  logic [3:0] unblk_dec; // Unblock counter after a failure
  logic [3:0] lc_idx; // Index of the last path byte pair
  // Data halves and addressed PIN
  always_comb begin
    first8 = cmd.data[0:7];
    second8 = cmd.data[8:15];
    pin_ok = (cmd.p2[6:5] == 2'h0) && (cmd.p2[4:0] != 5'h00) &&
             ({27'h0, cmd.p2[4:0]} <= NUM_PIN);
    pidx = PW'(cmd.p2[4:0] - 5'h01);
    pin_match = (first8 == pin_val_reg[pidx]);
    pin_dec = pin_cnt_reg[pidx] - 2'h1;
    unblk_dec = unblk_cnt_reg[pidx] - 4'h1;
  end
  // Target file lookup; the last two data bytes name the file
  always_comb begin
    lc_idx = 4'(cmd.lc - 8'h02);
    tgt_id = {cmd.data[lc_idx], cmd.data[4'(lc_idx + 4'h1)]};
    found = 1'b0;
    fidx = cur_ef_reg;
    if (cmd.lc == psf_pkg::LC_EMPTY) begin
      found = 1'b1;
    end else begin
      for (int i = NUM_FILE - 1; i >= 0; i--) begin
        if (file_id_reg[i] == tgt_id) begin
          found = 1'b1;
          fidx = FW'(i);
        end
      end
    end
  end
  // Evaluate one command; any rejection leaves every flag untouched
  always_comb begin
    sw_next = psf_pkg::SW_OK;
    en_good = 1'b0;
    en_bad = 1'b0;
    ub_good = 1'b0;
    ub_bad = 1'b0;
    file_do = 1'b0;
    unique case (cmd.kind)
      psf_pkg::PSF_ENABLE: begin
        if (cmd.lc != psf_pkg::LC_ENABLE) begin
          sw_next = psf_pkg::SW_BAD_LEN;
        end else if (cmd.p1 != psf_pkg::P1_ZERO) begin
          sw_next = psf_pkg::SW_BAD_P1P2;
        end else if (!pin_ok) begin
          sw_next = psf_pkg::SW_NO_REF;
        end else if (pin_blk_reg[pidx]) begin
          sw_next = psf_pkg::SW_BLOCKED;
        end else if (pin_en_reg[pidx]) begin
          sw_next = psf_pkg::SW_COND;
        end else if (pin_match) begin
          en_good = 1'b1;
        end else begin
          en_bad = 1'b1;
          sw_next = {psf_pkg::SW_RETRY_BASE, 2'h0, pin_dec};
        end
      end
      psf_pkg::PSF_UNBLOCK: begin
        if (cmd.p1 != psf_pkg::P1_ZERO) begin
          sw_next = psf_pkg::SW_BAD_P1P2;
        end else if (!pin_ok) begin
          sw_next = psf_pkg::SW_NO_REF;
        end else if (cmd.lc == psf_pkg::LC_EMPTY) begin
          // Query answers whatever the PIN blocked state; a blocked unblock PIN answers 6983
          if (unblk_blk_reg[pidx]) begin
            sw_next = psf_pkg::SW_BLOCKED;
          end else begin
            sw_next = {psf_pkg::SW_RETRY_BASE, unblk_cnt_reg[pidx]};
          end
        end else if (cmd.lc != psf_pkg::LC_UNBLOCK) begin
          sw_next = psf_pkg::SW_BAD_LEN;
        end else if (unblk_blk_reg[pidx]) begin
          sw_next = psf_pkg::SW_BLOCKED;
        end else if (first8 == unblk_val_reg[pidx]) begin
          ub_good = 1'b1;
        end else begin
          ub_bad = 1'b1;
          sw_next = {psf_pkg::SW_RETRY_BASE, unblk_dec};
        end
      end
      psf_pkg::PSF_DEACT, psf_pkg::PSF_ACT: begin
        if (cmd.p2 != psf_pkg::P1_ZERO) begin
          sw_next = psf_pkg::SW_BAD_P1P2;
        end else if (cmd.p1 != psf_pkg::P1_ZERO &&
                     cmd.p1 != psf_pkg::P1_PATH_ROOT &&
                     cmd.p1 != psf_pkg::P1_PATH_DF) begin
          sw_next = psf_pkg::SW_BAD_P1P2;
        end else if (cmd.lc == psf_pkg::LC_EMPTY &&
                     cmd.p1 != psf_pkg::P1_ZERO) begin
          sw_next = psf_pkg::SW_BAD_LEN;
        end else if (cmd.lc > psf_pkg::LC_UNBLOCK || cmd.lc[0] ||
                     (cmd.p1 == psf_pkg::P1_ZERO &&
                      cmd.lc > psf_pkg::LC_EMPTY &&
                      cmd.lc != 8'h02)) begin
          sw_next = psf_pkg::SW_BAD_LEN;
        end else if (!found) begin
          sw_next = psf_pkg::SW_NO_FILE;
        end else if (cmd.kind == psf_pkg::PSF_DEACT ? !deact_ok_reg[fidx]
                                                    : !act_ok_reg[fidx]) begin
          sw_next = psf_pkg::SW_SECURITY;
        end else begin
          file_do = 1'b1;
        end
      end
      psf_pkg::PSF_FILE_OP: begin
        // Any other operation on the current file is gated here
        if (file_deact_reg[cur_ef_reg]) begin
          sw_next = psf_pkg::SW_INVALID;
        end
      end
      default: begin
        sw_next = psf_pkg::SW_BAD_P1P2; // Unused kind codes
      end
    endcase
  end
  // ==========================================================
  // Register port decode
  logic wr_ctrl;
  logic format; // Reinitialise persistent state
  assign wr_ctrl = reg_wr && (reg_addr == psf_pkg::REG_CTRL);
  assign format = wr_ctrl && reg_wdata[psf_pkg::CTRL_FORMAT_BIT];
  // Command effects, valid only with cmd_valid
  logic do_en_good, do_en_bad, do_ub_good, do_ub_bad, do_file;
  assign do_en_good = cmd_valid && en_good;
  assign do_en_bad = cmd_valid && en_bad;
  assign do_ub_good = cmd_valid && ub_good;
  assign do_ub_bad = cmd_valid && ub_bad;
  assign do_file = cmd_valid && file_do;
  // ==========================================================
  // PIN state: not cleared by rst so counts carry across sessions
  always_ff @(posedge clk) begin
    if (format) begin
      for (int i = 0; i < NUM_PIN; i++) begin
        pin_cnt_reg[i] <= psf_pkg::PIN_INIT_TRIES;
        unblk_cnt_reg[i] <= psf_pkg::UNBLK_INIT_TRIES;
        qual_reg[i] <= psf_pkg::USE_QUAL_NONE;
        pin_val_reg[i] <= 64'h0;
        unblk_val_reg[i] <= 64'h0;
      end
      pin_en_reg <= '0;
      pin_blk_reg <= '0;
      unblk_blk_reg <= '0;
    end
    if (cmd_valid) begin // A command beats a same-cycle format
      if (do_en_good) begin
        pin_cnt_reg[pidx] <= psf_pkg::PIN_INIT_TRIES;
        pin_en_reg[pidx] <= 1'b1;
        qual_reg[pidx] <= psf_pkg::USE_QUAL_NONE;
      end
      if (do_en_bad) begin
        pin_cnt_reg[pidx] <= pin_dec;
        if (pin_dec == 2'h0) begin
          pin_blk_reg[pidx] <= 1'b1;
          pin_en_reg[pidx] <= BLOCK_SETS_ENABLE;
        end
      end
      if (do_ub_good) begin
        pin_val_reg[pidx] <= second8;
        unblk_cnt_reg[pidx] <= psf_pkg::UNBLK_INIT_TRIES;
        pin_cnt_reg[pidx] <= psf_pkg::PIN_INIT_TRIES;
        pin_en_reg[pidx] <= 1'b1;
        pin_blk_reg[pidx] <= 1'b0;
      end
      // A wrong unblock value touches only the unblock side
      if (do_ub_bad) begin
        unblk_cnt_reg[pidx] <= unblk_dec;
        if (unblk_dec == 4'h0) begin
          unblk_blk_reg[pidx] <= 1'b1;
        end
      end
    end else if (reg_wr) begin
      // Provisioning through the register window
      unique case (reg_addr)
        psf_pkg::REG_PIN_LO: pin_val_reg[sel_pin_reg][31:0] <= reg_wdata;
        psf_pkg::REG_PIN_HI: pin_val_reg[sel_pin_reg][63:32] <= reg_wdata;
        psf_pkg::REG_UNBLK_LO: unblk_val_reg[sel_pin_reg][31:0] <= reg_wdata;
        psf_pkg::REG_UNBLK_HI: unblk_val_reg[sel_pin_reg][63:32] <= reg_wdata;
        psf_pkg::REG_PIN_STAT: begin
          pin_en_reg[sel_pin_reg] <= reg_wdata[psf_pkg::STAT_EN_BIT];
          qual_reg[sel_pin_reg] <= reg_wdata[psf_pkg::STAT_QUAL_LSB +: 8];
        end
        default: begin
        end
      endcase
    end
  end
  // ==========================================================
  // Session verification and access condition output
  always_ff @(posedge clk) begin
    if (rst || format) begin
      verified_reg <= '0;
    end else begin
      if (do_en_good || do_ub_good) begin
        verified_reg[pidx] <= 1'b1;
      end
    end
  end
  // Disabled grants even when blocked; enabled needs a fresh verify
  always_ff @(posedge clk) begin
    if (rst) begin
      ac_reg <= '0;
    end else begin
      for (int i = 0; i < NUM_PIN; i++) begin
        ac_reg[i] <= !pin_en_reg[i] ||
                     (verified_reg[i] && !pin_blk_reg[i]);
      end
    end
  end
  // ==========================================================
  // File table: identifiers and access conditions set by software
  always_ff @(posedge clk) begin
    if (format) begin
      file_deact_reg <= '0;
      deact_ok_reg <= '0;
      act_ok_reg <= '0;
      for (int i = 0; i < NUM_FILE; i++) begin
        file_id_reg[i] <= 16'h0;
      end
    end
    if (do_file) begin
      // Reversible: activate simply clears the same flag
      file_deact_reg[fidx] <= (cmd.kind == psf_pkg::PSF_DEACT);
    end else if (reg_wr && reg_addr == psf_pkg::REG_FILE_CFG) begin
      file_id_reg[sel_file_reg] <= reg_wdata[15:0];
      deact_ok_reg[sel_file_reg] <= reg_wdata[psf_pkg::FCFG_DEACT_OK_BIT];
      act_ok_reg[sel_file_reg] <= reg_wdata[psf_pkg::FCFG_ACT_OK_BIT];
    end
  end
  // ==========================================================
  // Current file cursor; only rst, a successful file command or a REG_CURSOR write moves it
  always_ff @(posedge clk) begin
    if (rst) begin
      cur_ef_reg <= '0;
      cur_df_reg <= ROOT_FILE_ID;
    end else if (do_file) begin
      cur_ef_reg <= fidx;
    end else if (reg_wr && reg_addr == psf_pkg::REG_CURSOR) begin
      // Software moves the cursor through this register
      cur_ef_reg <= reg_wdata[FW-1:0];
      cur_df_reg <= reg_wdata[psf_pkg::CUR_DF_LSB +: 16];
    end
  end
  // Register window selectors
  always_ff @(posedge clk) begin
    if (rst) begin
      sel_pin_reg <= '0;
      sel_file_reg <= '0;
    end else if (reg_wr && reg_addr == psf_pkg::REG_SEL) begin
      sel_pin_reg <= reg_wdata[PW-1:0];
      sel_file_reg <= reg_wdata[psf_pkg::SEL_FILE_LSB +: FW];
    end
  end
  // ==========================================================
  // Answer: one cycle after the command
  always_ff @(posedge clk) begin
    if (rst) begin
      rsp_valid_reg <= 1'b0;
      rsp_sw_reg <= 16'h0000;
    end else begin
      rsp_valid_reg <= cmd_valid;
      rsp_sw_reg <= cmd_valid ? sw_next : 16'h0000;
    end
  end
  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst || !reg_rd) begin
      rdata_reg <= 32'h0;
    end else begin
      rdata_reg <= 32'h0; // Unused bits of every word read zero
      unique case (reg_addr)
        psf_pkg::REG_SEL: begin
          rdata_reg[PW-1:0] <= sel_pin_reg;
          rdata_reg[psf_pkg::SEL_FILE_LSB +: FW] <= sel_file_reg;
        end
        psf_pkg::REG_PIN_STAT: begin
          rdata_reg[1:0] <= pin_cnt_reg[sel_pin_reg];
          rdata_reg[psf_pkg::STAT_UCNT_LSB +: 4] <=
            unblk_cnt_reg[sel_pin_reg];
          rdata_reg[psf_pkg::STAT_EN_BIT] <= pin_en_reg[sel_pin_reg];
          rdata_reg[psf_pkg::STAT_BLK_BIT] <= pin_blk_reg[sel_pin_reg];
          rdata_reg[psf_pkg::STAT_UBLK_BIT] <= unblk_blk_reg[sel_pin_reg];
          rdata_reg[psf_pkg::STAT_VER_BIT] <= verified_reg[sel_pin_reg];
          rdata_reg[psf_pkg::STAT_QUAL_LSB +: 8] <= qual_reg[sel_pin_reg];
        end
        psf_pkg::REG_FILE_CFG: begin
          rdata_reg[15:0] <= file_id_reg[sel_file_reg];
          rdata_reg[psf_pkg::FCFG_DEACT_OK_BIT] <= deact_ok_reg[sel_file_reg];
          rdata_reg[psf_pkg::FCFG_ACT_OK_BIT] <= act_ok_reg[sel_file_reg];
          rdata_reg[psf_pkg::FCFG_DEACT_BIT] <= file_deact_reg[sel_file_reg];
        end
        psf_pkg::REG_CURSOR: begin
          rdata_reg[FW-1:0] <= cur_ef_reg;
          rdata_reg[psf_pkg::CUR_DF_LSB +: 16] <= cur_df_reg;
        end
        default: begin
          // Values are write-only and unmapped offsets read zero
          rdata_reg <= 32'h0;
        end
      endcase
    end
  end
  assign rsp_valid = rsp_valid_reg;
  assign rsp_sw = rsp_sw_reg;
  assign cur_ef = 8'(cur_ef_reg);
  assign ac_granted = ac_reg;
  assign reg_rdata = rdata_reg;
endmodule

// *** dv/psf_handler_chk.sv ***
// Port checker for the PIN state and file activation handler.
// Assumes it is bound into every psf_handler and sees its ports only.
module psf_handler_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire psf_pkg::psf_cmd_t cmd,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_sw,
  input wire logic [7:0] cur_ef
);
  // ==========================================================
  // Helper terms
  // One clock domain, so one default clocking serves all
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic en_cmd; // Enable taken
  logic ub_cmd; // Unblock taken
  logic f_cmd; // File (de)activation taken
  logic retry; // Answer is a retry count word
  assign en_cmd = cmd_valid && cmd.kind == psf_pkg::PSF_ENABLE;
  assign ub_cmd = cmd_valid && cmd.kind == psf_pkg::PSF_UNBLOCK;
  assign f_cmd = cmd_valid && (cmd.kind == psf_pkg::PSF_DEACT ||
    cmd.kind == psf_pkg::PSF_ACT);
  assign retry = rsp_sw[15:4] == psf_pkg::SW_RETRY_BASE;
  // ==========================================================
  // Properties
  property p_en_len;
    en_cmd && cmd.lc != 8'h08 |=> rsp_sw == psf_pkg::SW_BAD_LEN;
  endproperty
  a_en_len: assert property (p_en_len) else $error("enable length");
  property p_en_p1;
    en_cmd && cmd.lc == 8'h08 && cmd.p1 != 8'h00 |=> rsp_sw == 16'h6a86;
  endproperty
  a_en_p1: assert property (p_en_p1) else $error("enable p1");
  property p_ub_p1;
    ub_cmd && cmd.p1 != 8'h00 |=> rsp_sw == psf_pkg::SW_BAD_P1P2;
  endproperty
  a_ub_p1: assert property (p_ub_p1) else $error("unblock p1");
  property p_f_p2;
    f_cmd && (cmd.p2 != 8'h00 || !(cmd.p1 inside {8'h00, 8'h08, 8'h09}))
      |=> rsp_sw == psf_pkg::SW_BAD_P1P2;
  endproperty
  a_f_p2: assert property (p_f_p2) else $error("file p1 p2");
  // Failed file command must leave the current file alone
  property p_f_keep;
    f_cmd ##1 rsp_sw != psf_pkg::SW_OK |-> cur_ef == $past(cur_ef);
  endproperty
  a_f_keep: assert property (p_f_keep) else $error("cur_ef moved");
  // Query may report the full count of ten; failures never exceed nine
  property p_ub_code;
    ub_cmd && cmd.lc != 8'h00 |=>
      rsp_valid && !(retry && rsp_sw[3:0] > 4'h9);
  endproperty
  a_ub_code: assert property (p_ub_code) else $error("unblock count");
  property p_en_code;
    en_cmd |=> rsp_valid && !(retry && rsp_sw[3:0] > 4'h2);
  endproperty
  a_en_code: assert property (p_en_code) else $error("enable count");
  property p_ub_q;
    ub_cmd && cmd.lc == 8'h00 && cmd.p1 == 8'h00 |=> retry ||
      rsp_sw == psf_pkg::SW_BLOCKED || rsp_sw == psf_pkg::SW_NO_REF;
  endproperty
  a_ub_q: assert property (p_ub_q) else $error("unblock query");
  // ==========================================================
  // Main scenarios reached
  c_ok: cover property (cmd_valid ##1 rsp_sw == psf_pkg::SW_OK);
  c_blk: cover property (ub_cmd ##1 rsp_sw == psf_pkg::SW_BLOCKED);
  c_sec: cover property (f_cmd ##1 rsp_sw == psf_pkg::SW_SECURITY);
endmodule

bind psf_handler psf_handler_chk u_chk (.clk(clk), .rst(rst),
  .cmd_valid(cmd_valid), .cmd(cmd), .rsp_valid(rsp_valid),
  .rsp_sw(rsp_sw), .cur_ef(cur_ef));

// *** dv/psf_term.sv ***
// Terminal model: issues one command frame per call of send.
// Assumes the caller waits for the answer before the next frame.
module psf_term (
  input wire logic clk,
  output logic cmd_valid,
  output psf_pkg::psf_cmd_t cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Idle state at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  // One-cycle strobe; frame inverted once released so stale
  // fields never look valid
  task automatic send(input logic [2:0] k, input logic [7:0] p1, p2, lc,
    input logic [127:0] d);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= {psf_pkg::psf_kind_t'(k), p1, p2, lc, d};
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd <= ~cmd;
  endtask
endmodule

// *** dv/test_psf_handler.sv ***
// Self-checking bench for the PIN state and file activation handler.
// Assumes the terminal model sends frames; the bench owns registers.
module test_psf_handler;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals and counters
  logic clk = 1'b0; // 50 MHz
  logic rst = 1'b1;
  logic cmd_valid;
  psf_pkg::psf_cmd_t cmd;
  logic rsp_valid;
  logic [15:0] rsp_sw;
  logic [7:0] cur_ef;
  logic [3:0] ac_granted;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0; // Hang guard
  localparam logic [127:0] BAD = {64{2'h1}}; // Every byte wrong
  localparam logic [127:0] NEWP = {64'h0, {8{8'h11}}};
  initial forever #10 clk = ~clk;
  psf_handler #(.NUM_PIN(4), .NUM_FILE(8), .BLOCK_SETS_ENABLE(1'b0),
    .ROOT_FILE_ID(16'h0001)) DUT (.clk(clk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd(cmd), .rsp_valid(rsp_valid),
    .rsp_sw(rsp_sw), .cur_ef(cur_ef), .ac_granted(ac_granted),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  psf_term term (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd));
  // ==========================================================
  // Shared tasks
  task automatic chk(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", e, reg_rdata);
  endtask
  task automatic cm(input logic [2:0] k, input logic [7:0] p1, p2, lc,
    input logic [127:0] d, input logic [15:0] e);
    term.send(k, p1, p2, lc, d);
    #1;
    chk("rsp_valid", 32'h1, {31'h0, rsp_valid});
    chk("rsp_sw", {16'h0, e}, {16'h0, rsp_sw});
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Whole run needs about 120 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      test_done();
    end
  end
  // ==========================================================
  // Test sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wr(8'h00, 32'h1);
    rd(8'h00, 32'h0);
    rd(8'h3c, 32'h0);
    cm(3'h0, 8'h00, 8'h01, 8'h07, BAD, 16'h6700);
    cm(3'h0, 8'h01, 8'h01, 8'h08, BAD, 16'h6a86);
    cm(3'h0, 8'h00, 8'h00, 8'h08, BAD, 16'h6a88);
    cm(3'h0, 8'h00, 8'h61, 8'h08, BAD, 16'h6a88);
    cm(3'h0, 8'h00, 8'h01, 8'h08, BAD, 16'h63c2);
    rd(8'h18, 32'h0000_00a2);
    cm(3'h0, 8'h00, 8'h01, 8'h08, BAD, 16'h63c1);
    cm(3'h0, 8'h00, 8'h01, 8'h08, BAD, 16'h63c0);
    rd(8'h18, 32'h0000_02a0);
    chk("ac_granted", 32'h1, {31'h0, ac_granted[0]});
    cm(3'h0, 8'h00, 8'h01, 8'h08, '0, 16'h6983);
    wr(8'h18, 32'h0000_0100);
    rd(8'h18, 32'h0000_03a0);
    chk("ac_granted", 32'h0, {31'h0, ac_granted[0]});
    $display("test enable done");
    cm(3'h1, 8'h00, 8'h01, 8'h00, '0, 16'h63ca);
    cm(3'h1, 8'h00, 8'h01, 8'h10, BAD, 16'h63c9);
    rd(8'h18, 32'h0000_0390);
    cm(3'h1, 8'h01, 8'h01, 8'h10, NEWP, 16'h6a86);
    cm(3'h1, 8'h00, 8'h01, 8'h08, NEWP, 16'h6700);
    cm(3'h1, 8'h00, 8'h01, 8'h10, NEWP, 16'h9000);
    rd(8'h18, 32'h0000_09a3);
    chk("ac_granted", 32'h1, {31'h0, ac_granted[0]});
    cm(3'h0, 8'h00, 8'h81, 8'h08, '0, 16'h6985);
    $display("test unblock done");
    // PIN 1 stands in with a replacement qualifier set
    wr(8'h04, 32'h1);
    wr(8'h18, 32'h0008_0000);
    rd(8'h18, 32'h0008_00a3);
    cm(3'h0, 8'h00, 8'h02, 8'h08, '0, 16'h9000);
    rd(8'h18, 32'h0000_09a3);
    for (int i = 9; i >= 0; i--) begin
      cm(3'h1, 8'h00, 8'h02, 8'h10, BAD, {12'h63c, 4'(i)});
    end
    cm(3'h1, 8'h00, 8'h02, 8'h10, NEWP, 16'h6983);
    cm(3'h1, 8'h00, 8'h02, 8'h00, '0, 16'h6983);
    rd(8'h18, 32'h0000_0d03);
    $display("test unblock limit done");
    wr(8'h04, 32'h0100);
    wr(8'h1c, 32'h0003_2f00);
    wr(8'h04, 32'h0200);
    wr(8'h1c, 32'h0000_2f01);
    cm(3'h2, 8'h00, 8'h00, 8'h02, {16'h2f00, 112'h0}, 16'h9000);
    chk("cur_ef", 32'h1, {24'h0, cur_ef});
    wr(8'h04, 32'h0100);
    rd(8'h1c, 32'h0007_2f00);
    cm(3'h4, 8'h00, 8'h00, 8'h00, '0, 16'h6283);
    cm(3'h2, 8'h08, 8'h00, 8'h04, {32'h3f00_2f01, 96'h0}, 16'h6982);
    cm(3'h3, 8'h09, 8'h00, 8'h02, {16'h2f55, 112'h0}, 16'h6a82);
    chk("cur_ef", 32'h1, {24'h0, cur_ef});
    cm(3'h2, 8'h01, 8'h00, 8'h02, {16'h2f00, 112'h0}, 16'h6a86);
    cm(3'h3, 8'h00, 8'h01, 8'h02, {16'h2f00, 112'h0}, 16'h6a86);
    cm(3'h3, 8'h00, 8'h00, 8'h00, '0, 16'h9000);
    cm(3'h4, 8'h00, 8'h00, 8'h00, '0, 16'h9000);
    rd(8'h1c, 32'h0003_2f00);
    $display("test file done");
    // Session reset in mid-run; persistent state must survive
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(8'h18, 32'h0000_01a3);
    chk("cur_ef", 32'h0, {24'h0, cur_ef});
    $display("test persistence done");
    test_done();
  end
endmodule
